// File: hw/bus_phase_content.sv
// data bus content during the two execution phases, bank latch and halt
// assumes phase flags and operands come from logic on the same clock
`timescale 1ns/1ps

module bus_phase_content (
  input wire logic clock,
  input wire logic nrst,
  input wire cpu_bus_pkg::op_class_e op_class,
  input wire logic exec_phase_two,
  input wire logic exec_phase_three,
  input wire logic [cpu_bus_pkg::NIB_W-1:0] pair_even,
  input wire logic [cpu_bus_pkg::NIB_W-1:0] pair_odd,
  input wire logic [cpu_bus_pkg::NIB_W-1:0] reg_value,
  input wire logic [cpu_bus_pkg::NIB_W-1:0] acc,
  input wire logic carry_flag,
  input wire logic [cpu_bus_pkg::ADDR_W-1:0] saved_addr,
  input wire logic [cpu_bus_pkg::NIB_W-1:0] bus_in,
  output logic [cpu_bus_pkg::NIB_W-1:0] bus_out,
  output logic bus_oe,
  output logic [cpu_bus_pkg::NIB_W-1:0] read_data,
  output logic read_valid,
  output logic [cpu_bus_pkg::STROBE_W-1:0] ram_bank_strobe,
  output logic stopped
);

  // ------------------------------------------------------------------
  // run state
  // ------------------------------------------------------------------
  typedef enum logic {st_run, st_stopped} run_e;
  run_e state_q;
  run_e state_d;

  wire running;
  wire act_two;
  wire act_three;
  wire act_any;
  wire is_read;

  // phases arriving while stopped are ignored
  assign running = (state_q == st_run);
  assign act_two = exec_phase_two & running;
  assign act_three = exec_phase_three & running;
  assign act_any = act_two | act_three;
  assign is_read = (op_class == cpu_bus_pkg::op_mem_read);

  // only reset leaves the stopped state
  assign state_d = (act_three && op_class == cpu_bus_pkg::op_halt) ?
                   st_stopped : state_q;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q <= st_run;
    end else begin
      state_q <= state_d;
    end
  end

  assign stopped = (state_q == st_stopped);

  // ------------------------------------------------------------------
  // phase values
  // ------------------------------------------------------------------
  wire [cpu_bus_pkg::NIB_W-1:0] daa_value;
  wire [cpu_bus_pkg::NIB_W-1:0] kbp_value;
  wire [cpu_bus_pkg::NIB_W-1:0] write_tail;
  wire [cpu_bus_pkg::NIB_W-1:0] addr_high;
  wire [cpu_bus_pkg::NIB_W-1:0] addr_low;
  logic [cpu_bus_pkg::NIB_W-1:0] two_value;
  logic [cpu_bus_pkg::NIB_W-1:0] three_value;
  wire [cpu_bus_pkg::NIB_W-1:0] bus_out_d;
  wire bus_oe_d;

  // adjust when the digit overflowed decimal range or carried out
  assign daa_value = (acc > cpu_bus_pkg::DAA_LIMIT || carry_flag) ?
                     cpu_bus_pkg::DAA_ADJUST : cpu_bus_pkg::NIB_ZERO;
  assign kbp_value = cpu_bus_pkg::keypad_code(acc);
  assign write_tail = {cpu_bus_pkg::NIB_ONES[cpu_bus_pkg::NIB_W-1:1],
                       carry_flag};
  assign addr_high = saved_addr[cpu_bus_pkg::ADDR_W-1:cpu_bus_pkg::NIB_W];
  assign addr_low = saved_addr[cpu_bus_pkg::NIB_W-1:0];

  // phase two content per class
  function automatic logic [cpu_bus_pkg::NIB_W-1:0] pick_two(
    input cpu_bus_pkg::op_class_e op);
    case (op)
      cpu_bus_pkg::op_pair_load_immediate,
      cpu_bus_pkg::op_send_chip_address,
      cpu_bus_pkg::op_pair_load_indirect,
      cpu_bus_pkg::op_jump_via_pair: pick_two = pair_even;
      cpu_bus_pkg::op_register_swap: pick_two = reg_value;
      cpu_bus_pkg::op_mem_write: pick_two = acc;
      cpu_bus_pkg::op_decimal_adjust: pick_two = daa_value;
      cpu_bus_pkg::op_keypad_convert: pick_two = kbp_value;
      cpu_bus_pkg::op_interrupt_return: pick_two = addr_high;
      default: pick_two = cpu_bus_pkg::NIB_ONES;
    endcase
  endfunction : pick_two

  // phase three content per class
  function automatic logic [cpu_bus_pkg::NIB_W-1:0] pick_three(
    input cpu_bus_pkg::op_class_e op);
    case (op)
      cpu_bus_pkg::op_pair_load_immediate,
      cpu_bus_pkg::op_send_chip_address,
      cpu_bus_pkg::op_pair_load_indirect,
      cpu_bus_pkg::op_jump_via_pair: pick_three = pair_odd;
      cpu_bus_pkg::op_register_swap: pick_three = acc;
      cpu_bus_pkg::op_mem_write: pick_three = write_tail;
      cpu_bus_pkg::op_interrupt_return: pick_three = addr_low;
      default: pick_three = cpu_bus_pkg::NIB_ONES;
    endcase
  endfunction : pick_three

  // a process, not an assign: the picks read operands beyond their
  // argument, and an assign would miss a change of those operands
  always_comb begin
    two_value = pick_two(op_class);
    three_value = pick_three(op_class);
  end
  // idle bus rests at all ones so a late reader sees a neutral value
  assign bus_out_d = act_two ? two_value :
                     act_three ? three_value : cpu_bus_pkg::NIB_ONES;
  // reads leave the lines to the memory or port
  assign bus_oe_d = act_any & ~is_read;

  // bus driver registers; one cycle behind the phase flags
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bus_out <= cpu_bus_pkg::NIB_ONES;
      bus_oe <= 1'b0;
    end else begin
      bus_out <= bus_out_d;
      bus_oe <= bus_oe_d;
    end
  end

  // ------------------------------------------------------------------
  // read capture
  // ------------------------------------------------------------------
  logic [cpu_bus_pkg::NIB_W-1:0] bus_meta_q;
  logic [cpu_bus_pkg::NIB_W-1:0] bus_sync_q;
  logic [1:0] rd_phase_q;

  // pin data is two flops late, so the phase flag is delayed to match
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bus_meta_q <= cpu_bus_pkg::NIB_ZERO;
      bus_sync_q <= cpu_bus_pkg::NIB_ZERO;
      rd_phase_q <= 2'h0;
    end else begin
      bus_meta_q <= bus_in;
      bus_sync_q <= bus_meta_q;
      rd_phase_q <= {rd_phase_q[0], act_any & is_read};
    end
  end

  // take the memory data once it has crossed both flops
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      read_data <= cpu_bus_pkg::NIB_ZERO;
      read_valid <= 1'b0;
    end else begin
      read_valid <= rd_phase_q[1];
      if (rd_phase_q[1]) begin
        read_data <= bus_sync_q;
      end
    end
  end

  // ------------------------------------------------------------------
  // bank latch
  // ------------------------------------------------------------------
  logic [cpu_bus_pkg::BANK_W-1:0] bank_code_q;
  logic bank_loaded_q;
  wire bank_load;

  // load at the end of execution; accumulator bit 3 is dropped
  assign bank_load = act_three &&
                     op_class == cpu_bus_pkg::op_bank_line_select;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bank_code_q <= cpu_bus_pkg::BANK_RESET;
      bank_loaded_q <= 1'b0;
    end else if (bank_load) begin
      bank_code_q <= acc[cpu_bus_pkg::BANK_W-1:0];
      bank_loaded_q <= 1'b1;
    end
  end

  bank_strobe_decode u_strobe (
    .clock(clock),
    .nrst(nrst),
    .bank_code(bank_code_q),
    .ram_bank_strobe(ram_bank_strobe)
  );

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  wire pair_op;
  assign pair_op = op_class inside {cpu_bus_pkg::op_pair_load_immediate,
    cpu_bus_pkg::op_send_chip_address, cpu_bus_pkg::op_pair_load_indirect,
    cpu_bus_pkg::op_jump_via_pair};

  a_bank_default: assert property (
    !bank_loaded_q |-> ram_bank_strobe == cpu_bus_pkg::STROBE_BANK0)
    else $error("bank zero not selected before first bank select");
  a_bank_hold: assert property (
    !bank_load |=> $stable(bank_code_q))
    else $error("bank code changed without bank select");
  a_bank_strobe_map: assert property (
    bank_load |=> ##1 ram_bank_strobe ==
      cpu_bus_pkg::bank_decode($past(acc[cpu_bus_pkg::BANK_W-1:0], 2)))
    else $error("bank strobes do not match loaded code");
  a_bank_copy: assert property (
    bank_load |=> bank_code_q == $past(acc[cpu_bus_pkg::BANK_W-1:0]))
    else $error("bank code not copied from accumulator");
  a_pair_phases: assert property (
    pair_op && act_two ##1 pair_op && act_three |->
      bus_out == $past(pair_even) && bus_oe ##1 bus_out == $past(pair_odd))
    else $error("pair op bus content wrong");
  a_swap_phases: assert property (
    act_any && op_class == cpu_bus_pkg::op_register_swap |=>
      bus_oe && bus_out == ($past(act_two) ? $past(reg_value) : $past(acc)))
    else $error("register swap bus content wrong");
  a_write_phases: assert property (
    act_three && op_class == cpu_bus_pkg::op_mem_write |=>
      bus_out == {3'h7, $past(carry_flag)} && bus_oe)
    else $error("write phase three content wrong");
  a_read_release: assert property (
    act_any && is_read |=> !bus_oe ##2 read_valid)
    else $error("read did not release bus or capture data");
  a_keypad_value: assert property (
    act_two && op_class == cpu_bus_pkg::op_keypad_convert |=>
      bus_out == cpu_bus_pkg::keypad_code($past(acc)))
    else $error("keypad conversion value wrong");
  a_halt_stop: assert property (
    act_three && op_class == cpu_bus_pkg::op_halt |=>
      bus_out == cpu_bus_pkg::NIB_ONES && stopped ##1 !bus_oe)
    else $error("halt did not stop processor");
  a_return_addr: assert property (
    act_two && op_class == cpu_bus_pkg::op_interrupt_return |=>
      bus_out == $past(saved_addr[7:4]))
    else $error("interrupt return high nibble wrong");
  a_other_ones: assert property (
    act_any && op_class == cpu_bus_pkg::op_other |=>
      bus_out == cpu_bus_pkg::NIB_ONES && bus_oe)
    else $error("unlisted instruction did not drive ones");

endmodule : bus_phase_content

// File: shared/cpu_bus_pkg.sv
// constants, instruction classes and decode tables for the bus phase logic
// assumes the instruction decoder upstream reduces each opcode to a class
package cpu_bus_pkg;

  // ------------------------------------------------------------------
  // widths and fixed values
  // ------------------------------------------------------------------
  localparam int NIB_W = 4;
  localparam int ADDR_W = 8;
  localparam int BANK_W = 3;
  localparam int STROBE_W = 4;
  localparam logic [NIB_W-1:0] NIB_ONES = 4'hf;
  localparam logic [NIB_W-1:0] NIB_ZERO = 4'h0;
  localparam logic [NIB_W-1:0] DAA_ADJUST = 4'h6;
  localparam logic [NIB_W-1:0] DAA_LIMIT = 4'h9;
  localparam logic [BANK_W-1:0] BANK_RESET = 3'h0;
  localparam logic [STROBE_W-1:0] STROBE_BANK0 = 4'h1;

  // ------------------------------------------------------------------
  // instruction classes seen by the phase logic
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    op_other,
    op_pair_load_immediate,
    op_send_chip_address,
    op_pair_load_indirect,
    op_jump_via_pair,
    op_register_swap,
    op_mem_write,
    op_mem_read,
    op_decimal_adjust,
    op_keypad_convert,
    op_halt,
    op_interrupt_return,
    op_bank_line_select
  } op_class_e;

  // code bit n drives strobe n+1; all-zero code lights strobe 0
  function automatic logic [STROBE_W-1:0] bank_decode(
    input logic [BANK_W-1:0] code);
    bank_decode = {code, (code == BANK_RESET)};
  endfunction : bank_decode

  // one-hot to binary; anything not one-hot or zero flags error
  function automatic logic [NIB_W-1:0] keypad_code(
    input logic [NIB_W-1:0] a);
    case (a)
      4'h0: keypad_code = 4'h0;
      4'h1: keypad_code = 4'h1;
      4'h2: keypad_code = 4'h2;
      4'h4: keypad_code = 4'h3;
      4'h8: keypad_code = 4'h4;
      default: keypad_code = NIB_ONES;
    endcase
  endfunction : keypad_code

endpackage : cpu_bus_pkg

// File: hw/bank_strobe_decode.sv
// latched bank code to ram bank strobe lines, registered
// assumes the code input comes from a latch on the same clock
`timescale 1ns/1ps

module bank_strobe_decode (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [cpu_bus_pkg::BANK_W-1:0] bank_code,
  output logic [cpu_bus_pkg::STROBE_W-1:0] ram_bank_strobe
);

  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  wire [cpu_bus_pkg::STROBE_W-1:0] strobe_d;

  // banks 3, 5, 6 and 7 light several strobes at once
  assign strobe_d = cpu_bus_pkg::bank_decode(bank_code);

  // registered so the strobes never glitch while the code settles
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ram_bank_strobe <= cpu_bus_pkg::STROBE_BANK0;
    end else begin
      ram_bank_strobe <= strobe_d;
    end
  end

endmodule : bank_strobe_decode

// File: bench/mem_partner.sv
// memory side model: answers reads on the shared data lines
// assumes the bench raises sel only in a read phase cycle
`timescale 1ns/1ps

module mem_partner (
  input wire logic clock,
  input wire logic sel,
  input wire logic [3:0] addr,
  output logic [3:0] data
);
  logic [3:0] mem [16];
  logic [3:0] last_q;

  // fixed contents, distinct per address
  initial begin
    for (int i = 0; i < 16; i++) begin
      mem[i] = 4'(i * 7 + 3);
    end
    last_q = 4'h5;
  end

  // released lines float: inverse of last value, never a stale copy
  assign data = sel ? mem[addr] : ~last_q;
  always @(posedge clock) begin
    if (sel) last_q <= mem[addr];
  end
endmodule : mem_partner

// File: bench/bus_phase_content_tb.sv
// self-checking bench for the bus phase logic, with a memory model
// assumes the bench alone drives op class, phase flags and operands
`timescale 1ns/1ps

module bus_phase_content_tb;
  logic clock, nrst, exec_phase_two, exec_phase_three, carry_flag;
  cpu_bus_pkg::op_class_e op_class;
  logic [3:0] pair_even, pair_odd, reg_value, acc, bus_in, bus_out;
  logic [3:0] read_data, ram_bank_strobe, mem_data;
  logic [7:0] saved_addr;
  logic bus_oe, read_valid, stopped, sel;
  int failures, check_count, cycles, o;
  // model state; pipeline index 0 is due at the next check
  logic [3:0] e_bus, kb;
  logic e_oe, e_stop, e_skip, stop_m;
  logic [3:0] st_p [2];
  logic rv_p [3];
  logic [3:0] rd_p [3];
  logic [2:0] lat;

  // -------------------------------------------------------------
  // design, memory model and the shared line
  // -------------------------------------------------------------
  assign sel = (op_class == cpu_bus_pkg::op_mem_read) &&
               (exec_phase_two || exec_phase_three);
  assign bus_in = bus_oe ? bus_out : mem_data;
  mem_partner i_mem (.clock(clock), .sel(sel), .addr(pair_odd),
    .data(mem_data));
  bus_phase_content i_dut (.clock(clock), .nrst(nrst),
    .op_class(op_class), .exec_phase_two(exec_phase_two),
    .exec_phase_three(exec_phase_three), .pair_even(pair_even),
    .pair_odd(pair_odd), .reg_value(reg_value), .acc(acc),
    .carry_flag(carry_flag), .saved_addr(saved_addr), .bus_in(bus_in),
    .bus_out(bus_out), .bus_oe(bus_oe), .read_data(read_data),
    .read_valid(read_valid), .ram_bank_strobe(ram_bank_strobe),
    .stopped(stopped));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // hang guard, well above the ~1200 cycles the run needs
  always @(posedge clock) begin
    cycles++;
    if (cycles > 4000) begin
      failures++;
      end_sim();
    end
  end

  // -------------------------------------------------------------
  // tasks
  // -------------------------------------------------------------
  task automatic chk(input string what, input logic [3:0] exp,
                     input logic [3:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  // reset for six cycles; the model restarts with it
  task automatic rst();
    nrst <= 1'b0;
    exec_phase_two <= 1'b0;
    exec_phase_three <= 1'b0;
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    stop_m = 1'b0;
    lat = 3'h0;
    st_p = '{4'h1, 4'h1};
    rv_p = '{1'b0, 1'b0, 1'b0};
    {e_bus, e_oe, e_stop, e_skip} = {4'hf, 3'h0};
  endtask : rst

  // one cycle: check what the last cycle caused, then predict this one
  task automatic step(input int op, input logic p2, input logic p3);
    logic ph;
    @(posedge clock);
    op_class <= cpu_bus_pkg::op_class_e'(4'(op));
    exec_phase_two <= p2;
    exec_phase_three <= p3;
    {pair_even, pair_odd, reg_value, acc} <= 16'($urandom);
    saved_addr <= 8'($urandom);
    carry_flag <= 1'($urandom);
    #1;
    if (!e_skip) begin
      chk("bus_out", e_bus, bus_out);
    end
    chk("bus_oe", 4'(e_oe), 4'(bus_oe));
    chk("strobe", st_p[0], ram_bank_strobe);
    chk("stopped", 4'(e_stop), 4'(stopped));
    chk("read_valid", 4'(rv_p[0]), 4'(read_valid));
    if (rv_p[0]) chk("read_data", rd_p[0], read_data);
    ph = (p2 | p3) & ~stop_m;
    kb = (acc == 4'h0) ? 4'h0 : (acc == 4'h1) ? 4'h1 :
         (acc == 4'h2) ? 4'h2 : (acc == 4'h4) ? 4'h3 :
         (acc == 4'h8) ? 4'h4 : 4'hf;
    {e_bus, e_oe, e_skip} = {4'hf, ph, 1'b0};
    // expected phase content for the class under way
    if (ph) begin
      case (op)
        1, 2, 3, 4: e_bus = p2 ? pair_even : pair_odd;
        5: e_bus = p2 ? reg_value : acc;
        6: e_bus = p2 ? acc : {3'h7, carry_flag};
        7: {e_oe, e_skip} = 2'h1;
        8: e_bus = !p2 ? 4'hf : (acc > 9 || carry_flag) ? 4'h6 : 4'h0;
        9: e_bus = p2 ? kb : 4'hf;
        11: e_bus = p2 ? saved_addr[7:4] : saved_addr[3:0];
        default: e_bus = 4'hf;
      endcase
    end
    if (ph && p3 && op == 12) lat = acc[2:0];
    if (ph && p3 && op == 10) stop_m = 1'b1;
    e_stop = stop_m;
    st_p[0] = st_p[1];
    st_p[1] = {lat, lat == 3'h0};
    rv_p[0] = rv_p[1];
    rv_p[1] = rv_p[2];
    rd_p[0] = rd_p[1];
    rd_p[1] = rd_p[2];
    rv_p[2] = ph && op == 7;
    // memory contents at the addressed word, as the partner holds them
    rd_p[2] = 4'(pair_odd * 7 + 3);
  endtask : step

  // -------------------------------------------------------------
  // main sequence: random classes, then halt, then a second reset
  // -------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    op_class = cpu_bus_pkg::op_other;
    {exec_phase_two, exec_phase_three, carry_flag} = 3'h0;
    {pair_even, pair_odd, reg_value, acc, saved_addr} = 24'h0;
    {failures, check_count, cycles} = 0;
    void'($urandom(32'h543d11c4));
    rst();
    repeat (450) begin
      o = $urandom_range(12, 0);
      if (o == 10) o = 0;
      // drive lags its phase a cycle; a read right after would collide
      if (o == 7) step(0, 1'b0, 1'b0);
      step(o, 1'b1, 1'b0);
      step(o, 1'b0, 1'b1);
      if ($urandom_range(1, 0) == 1) step(0, 1'b0, 1'b0);
    end
    step(10, 1'b1, 1'b0);
    step(10, 1'b0, 1'b1);
    step(5, 1'b1, 1'b0);
    step(12, 1'b0, 1'b1);
    step(0, 1'b0, 1'b0);
    rst();
    step(0, 1'b0, 1'b0);
    step(0, 1'b0, 1'b0);
    end_sim();
  end
endmodule : bus_phase_content_tb
